// ### rtl/asc_ctrl.sv
// host controller driving an asynchronous 128k x 16 static memory
//
// Summary of operation
// - read holds write strobe high, chip select and gate low.
// - each read cycle lasts at least 10 ns between address changes.
// - address valid no later than chip select falling.
// - each write cycle lasts at least 10 ns.
// - write strobe low at least 7 ns with gate high.
// - write strobe low at least 10 ns with gate low.
// - chip select low at least 7 ns before write end.
// - byte select low at least 7 ns before write end.
// - address stable 7 ns before write end, may change at end.
// - data valid 5 ns before write end, zero hold.
`timescale 1ns/100ps
`include "asc_defs.svh"
module asc_ctrl (
  input  wire logic                   ref_clk,       // 20 MHz clock
  input  wire logic                   arst_n,        // async reset
  input  wire logic                   req_valid,     // request strobe
  input  wire logic                   req_write,     // 1 write, 0 read
  input  wire logic [`ASC_ADDR_W-1:0] req_addr,      // word address
  input  wire logic [1:0]             req_be,        // byte enables
  input  wire logic [`ASC_DATA_W-1:0] req_wdata,     // write data
  output logic                        req_ready,     // idle, can take
  output logic                        rsp_valid,     // read data pulse
  output logic [`ASC_DATA_W-1:0]      rsp_rdata,     // read data
  output logic [`ASC_ADDR_W-1:0]      mem_addr,      // address pins
  output logic                        chip_sel_n,    // chip select
  output logic                        write_n,       // write strobe
  output logic                        out_gate_n,    // output gate
  output logic                        low_byte_sel_n,  // bits 7:0
  output logic                        high_byte_sel_n, // bits 15:8
  output logic [`ASC_DATA_W-1:0]      dq_out,        // data to pins
  output logic                        dq_oe,         // drive data pins
  input  wire logic [`ASC_DATA_W-1:0] dq_in          // data from pins
);
  asc_pkg::asc_state_t  state_q;
  asc_pkg::asc_state_t  state_d;
  logic                 take;
  logic [1:0]           be_q;
  logic [1:0]           be_use;
  logic [`ASC_DATA_W-1:0] rd_sync;
  logic [1:0]           smp_q;

  asc_tmr_if tmr ();

  asc_timer u_timer (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .t       (tmr.tmr)
  );

  asc_rd_sync u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (dq_in),
    .dout    (rd_sync)
  );

  function automatic logic [`ASC_CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? `ASC_CNT_W'(1) : `ASC_CNT_W'(n);
  endfunction : cyc

  // phases in which the memory is selected and a lane may be enabled
  function automatic logic sel_phase(input asc_pkg::asc_state_t s);
    sel_phase = (s == asc_pkg::ASC_RACC ||
                 s == asc_pkg::ASC_WSET ||
                 s == asc_pkg::ASC_WPUL);
  endfunction : sel_phase

  // phases in which the controller owns the data pins
  function automatic logic drive_phase(input asc_pkg::asc_state_t s);
    drive_phase = (s == asc_pkg::ASC_WSET ||
                   s == asc_pkg::ASC_WPUL);
  endfunction : drive_phase

  // a request is taken only in idle while ready is shown
  assign take   = (state_q == asc_pkg::ASC_IDLE) && req_valid && req_ready;
  // lanes follow the new request on the edge that takes it
  assign be_use = take ? req_be : be_q;

  // next state and phase timer loads
  always_comb
  begin
    state_d   = state_q;
    tmr.load  = 1'b0;
    tmr.count = '0;
    case (state_q)
      asc_pkg::ASC_IDLE:
        if (take)
          state_d = req_write ? asc_pkg::ASC_WSET : asc_pkg::ASC_RSET;
      asc_pkg::ASC_RSET:
      begin
        state_d   = asc_pkg::ASC_RACC;
        tmr.load  = 1'b1;
        tmr.count = cyc(`ASC_AA_CYC + `ASC_RC_CYC);
      end
      asc_pkg::ASC_RACC:
        if (tmr.done && smp_q == 2'b11)
          state_d = asc_pkg::ASC_TURN;
      asc_pkg::ASC_WSET:
      begin
        state_d   = asc_pkg::ASC_WPUL;
        tmr.load  = 1'b1;
        tmr.count = cyc(`ASC_WP_CYC);
      end
      asc_pkg::ASC_WPUL:
        if (tmr.done)
          state_d = asc_pkg::ASC_WEND;
      asc_pkg::ASC_WEND:
      begin
        state_d   = asc_pkg::ASC_TURN;
        tmr.load  = 1'b1;
        tmr.count = cyc(`ASC_CYC_UP(`ASC_T_OW_NS));
      end
      asc_pkg::ASC_TURN:
        if (tmr.done)
          state_d = asc_pkg::ASC_IDLE;
      default:
        state_d = asc_pkg::ASC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= asc_pkg::ASC_IDLE;
    else
      state_q <= state_d;
  end

  // sync latency: wait three edges beyond the access time
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      smp_q <= 2'b00;
    else if (state_q != asc_pkg::ASC_RACC || !tmr.done)
      smp_q <= 2'b00;
    else if (smp_q != 2'b11)
      smp_q <= smp_q + 2'b01;
  end

  // byte enables held for the lane selects of the whole cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      be_q <= 2'b00;
    else if (take)
      be_q <= req_be;
  end

  // address stable from take to the end of the cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      mem_addr <= '0;
    else if (take)
      mem_addr <= req_addr;
  end

  // write data stands from setup through the write end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      dq_out <= '0;
    else if (take)
      dq_out <= req_wdata;
  end

  // chip select covers write setup, strobe and read access; rises with the strobe
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      chip_sel_n <= 1'b1;
    else
      chip_sel_n <= !sel_phase(state_d);
  end

  // strobe low only in the pulse phase, so it stays high through reads
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      write_n <= 1'b1;
    else
      write_n <= !(state_d == asc_pkg::ASC_WPUL);
  end

  // gate low only while reading, high for the whole write
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      out_gate_n <= 1'b1;
    else
      out_gate_n <= !(state_d == asc_pkg::ASC_RACC);
  end

  // a lane is enabled only for the bytes the request names
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_byte_sel_n  <= 1'b1;
      high_byte_sel_n <= 1'b1;
    end
    else
    begin
      low_byte_sel_n  <= !(sel_phase(state_d) && be_use[0]);
      high_byte_sel_n <= !(sel_phase(state_d) && be_use[1]);
    end
  end

  // drive only after the memory floated, release at write end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      dq_oe <= 1'b0;
    else
      dq_oe <= drive_phase(state_d);
  end

  // read return
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (state_q == asc_pkg::ASC_RACC &&
          state_d == asc_pkg::ASC_TURN)
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= rd_sync;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      req_ready <= 1'b0;
    else
      req_ready <= (state_d == asc_pkg::ASC_IDLE) && !take;
  end
endmodule : asc_ctrl

// ### rtl/asc_defs.svh
// timing and geometry constants for the async sram cycle controller
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_CLK_NS      50
`define ASC_ADDR_W      17
`define ASC_DATA_W      16
`define ASC_T_RC_NS     10
`define ASC_T_WC_NS     10
`define ASC_T_AA_NS     10
`define ASC_T_WP2_NS    10
`define ASC_T_OHZ_NS    5
`define ASC_T_OW_NS     3
`define ASC_CYC_UP(ns)  (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_RC_CYC      `ASC_CYC_UP(`ASC_T_RC_NS)
`define ASC_WC_CYC      `ASC_CYC_UP(`ASC_T_WC_NS)
`define ASC_AA_CYC      `ASC_CYC_UP(`ASC_T_AA_NS)
`define ASC_WP_CYC      `ASC_CYC_UP(`ASC_T_WP2_NS)
`define ASC_TURN_CYC    `ASC_CYC_UP(`ASC_T_OHZ_NS)
`define ASC_CNT_W       4
`endif

// ### rtl/asc_pkg.sv
// types for the async sram cycle controller
package asc_pkg;
  typedef enum logic [2:0] {
    ASC_IDLE  = 3'b000,
    ASC_RSET  = 3'b001,
    ASC_RACC  = 3'b010,
    ASC_WSET  = 3'b011,
    ASC_WPUL  = 3'b100,
    ASC_WEND  = 3'b101,
    ASC_TURN  = 3'b110
  } asc_state_t;
endpackage : asc_pkg

// ### rtl/asc_tmr_if.sv
// interface between the sequencer and its phase timer
`timescale 1ns/100ps
`include "asc_defs.svh"
interface asc_tmr_if;
  logic                   load;
  logic [`ASC_CNT_W-1:0]  count;
  logic                   done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : asc_tmr_if

// ### rtl/asc_timer.sv
// down counter that times the access, strobe and turnaround phases of a memory cycle
`timescale 1ns/100ps
`include "asc_defs.svh"
module asc_timer (
  input  wire logic ref_clk,  // system clock
  input  wire logic arst_n,   // async reset
  asc_tmr_if.tmr    t         // load and done
);
  logic [`ASC_CNT_W-1:0] cnt_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= '0;
    else if (t.load)
      cnt_q <= t.count;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 4'h1;
  end

  assign t.done = (cnt_q == '0) && !t.load;
endmodule : asc_timer

// ### rtl/asc_rd_sync.sv
// two flip-flop synchroniser for the data pins read back
`timescale 1ns/100ps
`include "asc_defs.svh"
module asc_rd_sync (
  input  wire logic                   ref_clk,  // system clock
  input  wire logic                   arst_n,   // async reset
  input  wire logic [`ASC_DATA_W-1:0] din,      // raw pins
  output logic      [`ASC_DATA_W-1:0] dout      // synchronised
);
  logic [`ASC_DATA_W-1:0] s1_q;
  logic [`ASC_DATA_W-1:0] s2_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  assign dout = s2_q;
endmodule : asc_rd_sync

// ### verif/asc_ctrl_asserts.sv
// pin-level assertions for the async sram cycle controller
`timescale 1ns/100ps
`include "asc_defs.svh"
module asc_ctrl_asserts (
  input wire logic                   ref_clk,         // clock
  input wire logic                   arst_n,          // reset
  input wire logic                   rsp_valid,       // read pulse
  input wire logic [`ASC_ADDR_W-1:0] mem_addr,        // address
  input wire logic                   chip_sel_n,      // chip select
  input wire logic                   write_n,         // write strobe
  input wire logic                   out_gate_n,      // output gate
  input wire logic                   low_byte_sel_n,  // low lane
  input wire logic                   high_byte_sel_n, // high lane
  input wire logic [`ASC_DATA_W-1:0] dq_out,          // write data
  input wire logic                   dq_oe            // data drive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rd_we; !chip_sel_n && !out_gate_n |-> write_n; endproperty
  a_rd_we: assert property (p_rd_we)
    else $error("write strobe low while reading");
  property p_no_fight; !out_gate_n |-> !dq_oe; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("data driven while gate low");
  property p_pulse;
    $fell(write_n) |-> !chip_sel_n && out_gate_n ##1 !write_n ##1 write_n;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("bad write pulse");
  property p_cs_end; $rose(write_n) |-> $past(!chip_sel_n, 2); endproperty
  a_cs_end: assert property (p_cs_end)
    else $error("chip select short before write end");
  property p_lane_end;
    $rose(write_n) |-> $past(low_byte_sel_n, 2) == $past(low_byte_sel_n)
      && $past(high_byte_sel_n, 2) == $past(high_byte_sel_n);
  endproperty
  a_lane_end: assert property (p_lane_end)
    else $error("lane select moved during write");
  property p_addr_end;
    $rose(write_n) |-> $past(mem_addr, 2) == $past(mem_addr);
  endproperty
  a_addr_end: assert property (p_addr_end)
    else $error("address moved during write");
  property p_data_end;
    $rose(write_n) |-> $past(dq_oe) && $past(dq_oe, 2)
      && $past(dq_out) == $past(dq_out, 2);
  endproperty
  a_data_end: assert property (p_data_end)
    else $error("write data not held");
  property p_addr_sel;
    !chip_sel_n && $past(!chip_sel_n) |-> $stable(mem_addr);
  endproperty
  a_addr_sel: assert property (p_addr_sel)
    else $error("address changed while selected");
  property p_sample;
    $fell(out_gate_n) |-> !rsp_valid [*2] ##[1:8] rsp_valid;
  endproperty
  a_sample: assert property (p_sample)
    else $error("read data taken at wrong time");
endmodule : asc_ctrl_asserts
bind asc_ctrl asc_ctrl_asserts i_chk (.ref_clk, .arst_n, .rsp_valid,
  .mem_addr, .chip_sel_n, .write_n, .out_gate_n, .low_byte_sel_n,
  .high_byte_sel_n, .dq_out, .dq_oe);

// ### verif/asc_sram_model.sv
// behavioural model of the asynchronous 128k x 16 static memory
`timescale 1ns/100ps
`include "asc_defs.svh"
module asc_sram_model (
  input  wire logic [`ASC_ADDR_W-1:0] mem_addr,        // address
  input  wire logic                   chip_sel_n,      // chip select
  input  wire logic                   write_n,         // write strobe
  input  wire logic                   out_gate_n,      // output gate
  input  wire logic                   low_byte_sel_n,  // low lane
  input  wire logic                   high_byte_sel_n, // high lane
  input  wire logic [`ASC_DATA_W-1:0] dq_wr,           // pin level
  output logic      [`ASC_DATA_W-1:0] dq_rd,           // read data
  output logic      [1:0]             dq_en            // lanes driven
);
  logic [`ASC_DATA_W-1:0] mem [logic [`ASC_ADDR_W-1:0]];
  logic [`ASC_ADDR_W-1:0] a_d;
  logic [`ASC_DATA_W-1:0] d_d;
  logic [1:0]             sel_d;
  logic                   act_d;
  // 1 ns lag keeps the values from before the write-ending edge
  assign #1 a_d = mem_addr;
  assign #1 d_d = dq_wr;
  assign #1 sel_d = {high_byte_sel_n, low_byte_sel_n};
  assign #1 act_d = !chip_sel_n && !write_n;
  always @(posedge write_n or posedge chip_sel_n)
    if (act_d)
    begin
      if (!sel_d[0]) mem[a_d][7:0] = d_d[7:0];
      if (!sel_d[1]) mem[a_d][15:8] = d_d[15:8];
    end
  assign dq_en[0] = !chip_sel_n && !out_gate_n && write_n
                    && !low_byte_sel_n;
  assign dq_en[1] = !chip_sel_n && !out_gate_n && write_n
                    && !high_byte_sel_n;
  always @(mem_addr, write_n, chip_sel_n)
  begin
    #3;
    dq_rd = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
  end
endmodule : asc_sram_model

// ### verif/asc_ctrl_bench.sv
// self-checking bench for the async sram cycle controller
`timescale 1ns/100ps
`include "asc_defs.svh"
`define ASC_CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin \
  fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module asc_ctrl_bench;
  logic                   ref_clk, arst_n, req_valid, req_write, req_ready;
  logic                   rsp_valid, chip_sel_n, write_n, out_gate_n, dq_oe;
  logic                   low_byte_sel_n, high_byte_sel_n;
  logic [1:0]             req_be, dq_en;
  logic [`ASC_ADDR_W-1:0] req_addr, mem_addr, ad [8];
  logic [`ASC_DATA_W-1:0] req_wdata, rsp_rdata, dq_out, dq_in, dq_rd, junk;
  logic [`ASC_DATA_W-1:0] shadow [int];
  logic [31:0]            exp_q [$];
  logic [31:0]            note;
  int                     fail_count, compares;
  always #25 ref_clk = ~ref_clk;
  // released lanes show a changing pattern, never the last value
  always @(posedge ref_clk) junk <= ~junk + 16'h3C5A;
  assign dq_in = dq_oe ? dq_out : {dq_en[1] ? dq_rd[15:8] : junk[15:8],
                                   dq_en[0] ? dq_rd[7:0] : junk[7:0]};
  asc_ctrl i_dut (.ref_clk, .arst_n, .req_valid, .req_write, .req_addr,
    .req_be, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
    .chip_sel_n, .write_n, .out_gate_n, .low_byte_sel_n, .high_byte_sel_n,
    .dq_out, .dq_oe, .dq_in);
  asc_sram_model i_mem (.mem_addr, .chip_sel_n, .write_n, .out_gate_n,
    .low_byte_sel_n, .high_byte_sel_n, .dq_wr(dq_in), .dq_rd, .dq_en);
  task complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task wait_ready;
    int n;
    n = 0;
    while (req_ready !== 1'h1 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (req_ready !== 1'h1)
    begin
      fail_count++;
      $display("unexpected req_ready exp 1 got %h", req_ready);
      complete_run();
    end
  endtask : wait_ready
  task do_req(input logic w, input logic [16:0] a, input logic [1:0] be,
              input logic [15:0] d);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    wait_ready();
    req_valid = 1'h1;
    req_write = w;
    req_addr = a;
    req_be = be;
    req_wdata = d;
    if (w)
      shadow[a] = (shadow[a] & ~m) | (d & m);
    else
      exp_q.push_back({m, shadow[a] & m});
    @(posedge ref_clk);
    #1;
    req_valid = 1'h0;
  endtask : do_req
  always @(posedge ref_clk)
    if (rsp_valid === 1'h1)
    begin
      if (exp_q.size() == 0)
        `ASC_CHK("rsp_valid", 1'h0, 1'h1)
      else
      begin
        note = exp_q.pop_front();
        `ASC_CHK("rsp_rdata", note[15:0], rsp_rdata & note[31:16])
      end
    end
  initial
  begin
    {ref_clk, arst_n, req_valid, req_write, req_be} = 6'h00;
    {req_addr, req_wdata, junk} = 49'h0;
    fail_count = 0;
    compares = 0;
    void'($urandom(98534));
    repeat (8) @(posedge ref_clk);
    #1;
    arst_n = 1'h1;
    foreach (ad[i]) ad[i] = 17'($urandom);
    ad[0] = 17'h00000;
    ad[7] = 17'h1FFFF;
    foreach (ad[i]) do_req(1'h1, ad[i], 2'h3, 16'($urandom));
    foreach (ad[i]) do_req(1'h0, ad[i], 2'h3, 16'h0000);
    for (int b = 0; b < 4; b++)
    begin
      do_req(1'h1, ad[0], 2'(b), 16'($urandom));
      do_req(1'h0, ad[0], 2'h3, 16'h0000);
      do_req(1'h0, ad[1], 2'(b), 16'h0000);
    end
    // a request while busy must be ignored
    do_req(1'h0, ad[2], 2'h3, 16'h0000);
    @(posedge ref_clk);
    #1;
    req_valid = 1'h1;
    req_write = 1'h1;
    req_wdata = ~shadow[ad[2]];
    @(posedge ref_clk);
    #1;
    req_valid = 1'h0;
    do_req(1'h0, ad[2], 2'h3, 16'h0000);
    // reset in the middle of a write
    do_req(1'h1, ad[3], 2'h3, 16'($urandom));
    @(posedge ref_clk);
    #1;
    arst_n = 1'h0;
    #1;
    `ASC_CHK("chip_sel_n", 1'h1, chip_sel_n)
    `ASC_CHK("dq_oe", 1'h0, dq_oe)
    `ASC_CHK("req_ready", 1'h0, req_ready)
    repeat (2) @(posedge ref_clk);
    #1;
    arst_n = 1'h1;
    do_req(1'h0, ad[4], 2'h3, 16'h0000);
    repeat (12) @(posedge ref_clk);
    `ASC_CHK("pending reads", 0, exp_q.size())
    complete_run();
  end
endmodule : asc_ctrl_bench
